// ===== design/cpsf_params.svh
`ifndef CPSF_PARAMS_SVH
`define CPSF_PARAMS_SVH

`define CPSF_PAGE_W 3
`define CPSF_PAGE_FACTORY 3'h0
`define CPSF_PAGE_LOCAL_APP 3'h1
`define CPSF_PAGE_RESET 3'h0
`define CPSF_SYNC_FILL 3'h4
`define CPSF_WDOG_CYCLES 1000000

`endif

// ===== design/cpsf_pkg.sv
package cpsf_pkg;

  typedef enum logic [2:0] {
    CPSF_ST_POR  = 3'b001,
    CPSF_ST_LOAD = 3'b010,
    CPSF_ST_USER = 3'b100
  } cpsf_state_t;

  typedef enum logic [1:0] {
    CPSF_WHY_POWER_UP = 2'h0,
    CPSF_WHY_LOAD_ERR = 2'h1,
    CPSF_WHY_WDOG = 2'h2,
    CPSF_WHY_REQUEST = 2'h3
  } cpsf_reason_t;

  typedef enum logic {
    CPSF_PASSIVE_SERIAL_MODE = 1'b0,
    CPSF_FAST_PASSIVE_PARALLEL_MODE = 1'b1
  } cpsf_scheme_t;

endpackage

// ===== design/cpsf_wdog_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cpsf_wdog_if;
  logic enable;
  logic clear;
  logic expired;
  modport ctrl (output enable, output clear, input expired);
  modport timer (input enable, input clear, output expired);
endinterface
`default_nettype wire

// ===== design/cpsf_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_params.svh"
module cpsf_watchdog #(
  parameter int WDOG_CYCLES = `CPSF_WDOG_CYCLES
) (
  input wire logic CLOCK, // Block clock.
  input wire logic RST_N, // Asynchronous reset, active low.
  cpsf_wdog_if.timer wd // Enable, clear and expiry pulse.
);
  localparam int CW = $clog2(WDOG_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(WDOG_CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic expired_reg;

  // The counter sits at zero while the clear is high or the timer is idle.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      count_reg <= '0;
    end else if (!wd.enable || wd.clear) begin
      count_reg <= '0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= wd.enable && !wd.clear && (count_reg == LAST);
    end
  end

  assign wd.expired = expired_reg;
endmodule
`default_nettype wire

// ===== design/cpsf_config_loader.sv
// What this block does
// - Only the passive serial and fast passive parallel schemes are used with the external configuration device.
// - The page select lines go straight to the configuration device, which sends only the named page.
// - Power-up in remote mode presents page 000 and loads the factory image.
// - User mode is entered only after an image loads without error from the selected page.
// - The running factory image reads the status and picks the next application page.
// - A load error on an application or a watchdog expiry in user mode reloads the factory image.
// - Power-up in local mode presents page 001 and loads the application there.
// - In local mode an application load error falls back to the factory image on its own.
// - Everything except the asynchronous active-low reset is evaluated on the rising clock edge.
// - The watchdog counter is held in reset while its clear input is high.
// - In user mode a rising reconfiguration request starts a new configuration cycle.
// - The three-bit page select carries page 000 to 111 of the image being loaded.
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_params.svh"
module cpsf_config_loader #(
  parameter int WDOG_CYCLES = `CPSF_WDOG_CYCLES
) (
  input wire logic CLOCK, // Block clock, 50 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic LOCAL_MODE, // Strap pin: 1 local, 0 remote configuration.
  input wire logic FPP_MODE, // Strap pin: 1 fast passive parallel, 0 passive serial.
  input wire logic LOAD_DONE, // Pin: image load finished without error.
  input wire logic LOAD_ERROR, // Pin: error during image load.
  input wire logic RECONFIG_REQ, // User logic: rising level starts reconfiguration.
  input wire logic WDOG_CLEAR, // User logic: holds the watchdog cleared.
  input wire logic [`CPSF_PAGE_W-1:0] NEXT_PAGE, // Page the factory image chose.
  output logic [`CPSF_PAGE_W-1:0] PAGE_SELECT, // Page select to the configuration device.
  output logic CONFIG_START, // One-cycle pulse opening a configuration cycle.
  output logic USER_MODE, // Device is in user mode.
  output logic APP_RUNNING, // Current image is an application, not the factory.
  output var cpsf_pkg::cpsf_reason_t LAST_REASON, // Status: why the last load was started.
  output var cpsf_pkg::cpsf_scheme_t SCHEME // Configuration scheme caught from the strap.
);
  import cpsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree.
  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
  assign pin_raw = {LOAD_ERROR, LOAD_DONE, FPP_MODE, LOCAL_MODE};

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_filt
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          pin_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          pin_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  logic done_d_reg, err_d_reg, req_d_reg;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      done_d_reg <= 1'b0;
      err_d_reg <= 1'b0;
      req_d_reg <= 1'b0;
    end else begin
      done_d_reg <= pin_reg[2];
      err_d_reg <= pin_reg[3];
      req_d_reg <= RECONFIG_REQ;
    end
  end

  logic done_rise, err_rise, req_rise;
  assign done_rise = pin_reg[2] && !done_d_reg;
  assign err_rise = pin_reg[3] && !err_d_reg;
  assign req_rise = RECONFIG_REQ && !req_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, armed only while an application runs in user mode.
  cpsf_wdog_if wd ();
  assign wd.enable = USER_MODE && APP_RUNNING;
  assign wd.clear = WDOG_CLEAR;

  cpsf_watchdog #(
    .WDOG_CYCLES(WDOG_CYCLES)
  ) u_wdog (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .wd(wd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Straps are caught only after the synchronisers and the
  // agreement filter have filled: three stages plus the filter need four
  // edges, so the first start goes out on the fifth edge after reset.
  // Catching them one edge earlier would read the filter's reset value.
  cpsf_state_t state_reg;
  logic [2:0] fill_reg;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fill_reg <= '0;
    end else if (fill_reg != `CPSF_SYNC_FILL) begin
      fill_reg <= fill_reg + 1'b1;
    end
  end

  logic por_go;
  assign por_go = (state_reg == CPSF_ST_POR) && (fill_reg == `CPSF_SYNC_FILL);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SCHEME <= CPSF_PASSIVE_SERIAL_MODE;
    end else if (por_go) begin
      SCHEME <= pin_reg[1] ? CPSF_FAST_PASSIVE_PARALLEL_MODE : CPSF_PASSIVE_SERIAL_MODE;
    end
  end

  // Page and reason change only together with a start pulse, so the page
  // seen by the configuration device never moves during a load.
  logic start_next;
  logic [`CPSF_PAGE_W-1:0] page_next;
  cpsf_reason_t why_next;

  always_comb begin
    start_next = 1'b0;
    page_next = PAGE_SELECT;
    why_next = LAST_REASON;
    unique case (state_reg)
      CPSF_ST_POR: begin
        if (por_go) begin
          start_next = 1'b1;
          why_next = CPSF_WHY_POWER_UP;
          page_next = pin_reg[0] ? `CPSF_PAGE_LOCAL_APP : `CPSF_PAGE_FACTORY;
        end
      end
      CPSF_ST_LOAD: begin
        if (err_rise) begin
          // A failed factory load is simply retried from the factory page.
          start_next = 1'b1;
          why_next = CPSF_WHY_LOAD_ERR;
          page_next = `CPSF_PAGE_FACTORY;
        end
      end
      CPSF_ST_USER: begin
        if (wd.expired) begin
          start_next = 1'b1;
          why_next = CPSF_WHY_WDOG;
          page_next = `CPSF_PAGE_FACTORY;
        end else if (req_rise) begin
          start_next = 1'b1;
          why_next = CPSF_WHY_REQUEST;
          page_next = APP_RUNNING ? `CPSF_PAGE_FACTORY : NEXT_PAGE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PAGE_SELECT <= `CPSF_PAGE_RESET;
      LAST_REASON <= CPSF_WHY_POWER_UP;
      CONFIG_START <= 1'b0;
    end else begin
      CONFIG_START <= start_next;
      if (start_next) begin
        PAGE_SELECT <= page_next;
        LAST_REASON <= why_next;
      end
    end
  end

  // A load counts as good only if no error is seen with the done edge.
  logic load_good;
  assign load_good = (state_reg == CPSF_ST_LOAD) && done_rise && !pin_reg[3];

  // The state, the user flag and the image kind each keep their own block;
  // all three move on the same edges, so the outputs never disagree.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= CPSF_ST_POR;
    end else if (start_next) begin
      state_reg <= CPSF_ST_LOAD;
    end else if (load_good) begin
      state_reg <= CPSF_ST_USER;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      USER_MODE <= 1'b0;
    end else if (start_next) begin
      USER_MODE <= 1'b0;
    end else if (load_good) begin
      USER_MODE <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      APP_RUNNING <= 1'b0;
    end else if (start_next) begin
      APP_RUNNING <= 1'b0;
    end else if (load_good) begin
      APP_RUNNING <= (PAGE_SELECT != `CPSF_PAGE_FACTORY);
    end
  end
endmodule
`default_nettype wire

// ===== tb/cpsf_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpsf_params.svh"
module cpsf_monitor
  import cpsf_pkg::*;
#(
  parameter int WDOG_CYCLES = 20
) (
  input wire logic CLOCK, // Clock.
  input wire logic RST_N, // Reset.
  input wire logic LOAD_DONE, // Load ok.
  input wire logic LOAD_ERROR, // Load failed.
  input wire logic RECONFIG_REQ, // Request.
  input wire logic WDOG_CLEAR, // Watchdog clear.
  input wire logic [`CPSF_PAGE_W-1:0] NEXT_PAGE, // Chosen page.
  input wire logic [`CPSF_PAGE_W-1:0] PAGE_SELECT, // Page out.
  input wire logic CONFIG_START, // Start pulse.
  input wire logic USER_MODE, // User mode.
  input wire logic APP_RUNNING, // Application up.
  input wire cpsf_reason_t LAST_REASON // Reason.
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  int wd_cnt;
  // Counts unserviced application cycles, so expiry can be given a tight window.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) wd_cnt <= 0;
    else if (USER_MODE && APP_RUNNING && !WDOG_CLEAR) wd_cnt <= wd_cnt + 1;
    else wd_cnt <= 0;
  end
  ////////////////////////////////////////
  a_page_stable:
    assert property (!CONFIG_START |-> $stable(PAGE_SELECT)) else $error("page moved mid load");
  a_req_start:
    assert property (USER_MODE && WDOG_CLEAR && $rose(RECONFIG_REQ) |=> CONFIG_START
      && LAST_REASON == CPSF_WHY_REQUEST && PAGE_SELECT == ($past(APP_RUNNING) ? 3'h0 : $past(NEXT_PAGE)))
    else $error("request start wrong");
  a_user_drop:
    assert property (CONFIG_START |-> !USER_MODE && !APP_RUNNING) else $error("user mode during start");
  a_user_load:
    assert property ($rose(USER_MODE) |-> LOAD_DONE && !LOAD_ERROR && $past(LOAD_DONE, 3))
    else $error("user mode without good load");
  a_app_flag:
    assert property (USER_MODE |-> APP_RUNNING == (PAGE_SELECT != 3'h0)) else $error("app flag wrong");
  a_err_back:
    assert property ($rose(LOAD_ERROR) |-> ##[1:8] (CONFIG_START && PAGE_SELECT == 3'h0
      && LAST_REASON == CPSF_WHY_LOAD_ERR)) else $error("no fallback after error");
  a_wdog_late:
    assert property (wd_cnt == WDOG_CYCLES |-> ##[0:4] (CONFIG_START && LAST_REASON == CPSF_WHY_WDOG))
    else $error("watchdog did not expire");
  // An expiry flagged on the edge before the clear rose may still act, so the
  // clear must have stood for two sampled edges.
  a_wdog_hold:
    assert property (USER_MODE && WDOG_CLEAR && $past(WDOG_CLEAR) && !RECONFIG_REQ |=> !CONFIG_START)
    else $error("start while cleared");
  c_app_up: cover property ($rose(USER_MODE) && APP_RUNNING);
  c_wdog: cover property (CONFIG_START && LAST_REASON == CPSF_WHY_WDOG);
  c_err: cover property (CONFIG_START && LAST_REASON == CPSF_WHY_LOAD_ERR);
endmodule
bind cpsf_config_loader cpsf_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) cpsf_monitor_i (.CLOCK(CLOCK), .RST_N(RST_N),
  .LOAD_DONE(LOAD_DONE), .LOAD_ERROR(LOAD_ERROR), .RECONFIG_REQ(RECONFIG_REQ), .WDOG_CLEAR(WDOG_CLEAR),
  .NEXT_PAGE(NEXT_PAGE), .PAGE_SELECT(PAGE_SELECT), .CONFIG_START(CONFIG_START), .USER_MODE(USER_MODE),
  .APP_RUNNING(APP_RUNNING), .LAST_REASON(LAST_REASON));
`default_nettype wire

// ===== tb/cpsf_cfg_device.sv
`timescale 1ns/100ps
`default_nettype none
module cpsf_cfg_device (
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic config_start, // Start of a load.
  input wire logic [2:0] page_select, // Page to send.
  input wire logic [7:0] err_pages, // Pages holding a corrupt image.
  input wire logic slow, // Long load.
  output logic load_done, // Load finished.
  output logic load_error // Load failed.
);
  localparam logic [31:0] PAGE0_BASE = 32'h00010040;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  logic [5:0] wait_reg;
  ////////////////////////////////////////
  // Answers stay up until the next start, as the real pins would.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 6'h00;
      load_done <= 1'h0;
      load_error <= 1'h0;
    end else if (config_start) begin
      wait_reg <= slow ? 6'h28 : 6'h02;
      load_done <= 1'h0;
      load_error <= 1'h0;
    end else if (wait_reg == 6'h01) begin
      wait_reg <= 6'h00;
      load_error <= err_pages[page_select];
      load_done <= !err_pages[page_select];
    end else if (wait_reg != 6'h00) begin
      wait_reg <= wait_reg - 6'h01;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_config_page_select_fallback.sv
`timescale 1ns/100ps
`default_nettype none
module tb_config_page_select_fallback;
  import cpsf_pkg::*;
  localparam int W = 20;
  logic clock = 1'h0, rst_n = 1'h0, local_mode = 1'h0, fpp_mode = 1'h0, reconfig_req = 1'h0, slow = 1'h0;
  logic wdog_clear = 1'h1;
  logic load_done, load_error, config_start, user_mode, app_running;
  logic [2:0] next_page = 3'h0, page_select;
  logic [7:0] err_pages = 8'h00;
  cpsf_reason_t last_reason;
  cpsf_scheme_t scheme;
  int bad_count = 0, check_count = 0, cyc = 0, n;
  always #10 clock = ~clock;
  cpsf_config_loader #(.WDOG_CYCLES(W)) cpsf_config_loader_i (.CLOCK(clock), .RST_N(rst_n),
    .LOCAL_MODE(local_mode), .FPP_MODE(fpp_mode), .LOAD_DONE(load_done), .LOAD_ERROR(load_error),
    .RECONFIG_REQ(reconfig_req), .WDOG_CLEAR(wdog_clear), .NEXT_PAGE(next_page), .PAGE_SELECT(page_select),
    .CONFIG_START(config_start), .USER_MODE(user_mode), .APP_RUNNING(app_running),
    .LAST_REASON(last_reason), .SCHEME(scheme));
  cpsf_cfg_device cpsf_cfg_device_i (.clock(clock), .rst_n(rst_n), .config_start(config_start),
    .page_select(page_select), .err_pages(err_pages), .slow(slow), .load_done(load_done),
    .load_error(load_error));
  ////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input bit u);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((u ? user_mode : config_start) !== 1'h1 && n < 400);
    chk(3'(n < 400), 3'h1);
  endtask
  task automatic land(input logic [2:0] pg);
    if (err_pages[pg]) begin
      wt(0);
      chk(page_select, 3'h0);
      chk({1'h0, last_reason}, {1'h0, CPSF_WHY_LOAD_ERR});
    end
    wt(1);
    chk({2'h0, app_running}, {2'h0, pg != 3'h0 && !err_pages[pg]});
  endtask
  task automatic boot(input logic lm, input logic fm);
    @(posedge clock);
    rst_n <= 1'h0;
    local_mode <= lm;
    fpp_mode <= fm;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    wt(0);
    chk(page_select, {2'h0, lm});
    chk({2'h0, scheme}, {2'h0, fm});
    chk({1'h0, last_reason}, {1'h0, CPSF_WHY_POWER_UP});
    land({2'h0, lm});
  endtask
  task automatic req(input logic [2:0] nx, input logic [2:0] pg);
    @(posedge clock);
    next_page <= nx;
    reconfig_req <= 1'h1;
    wt(0);
    chk(page_select, pg);
    chk({1'h0, last_reason}, {1'h0, CPSF_WHY_REQUEST});
    @(posedge clock);
    reconfig_req <= 1'h0;
    land(pg);
  endtask
  task automatic wdog;
    repeat (3 * W) @(posedge clock);
    #1;
    chk({2'h0, user_mode}, 3'h1);
    @(posedge clock);
    wdog_clear <= 1'h0;
    wt(0);
    chk(3'(n > W), 3'h1);
    chk(page_select, 3'h0);
    chk({1'h0, last_reason}, {1'h0, CPSF_WHY_WDOG});
    @(posedge clock);
    wdog_clear <= 1'h1;
    land(3'h0);
  endtask
  initial begin
    boot(1'h0, 1'h1);
    for (int p = 1; p < 8; p++) begin
      slow <= p[0];
      req(3'(p), 3'(p));
      if (p == 3) wdog();
      else req(3'h5, 3'h0);
    end
    err_pages <= 8'h40;
    req(3'h6, 3'h6);
    err_pages <= 8'h02;
    boot(1'h1, 1'h0);
    err_pages <= 8'h00;
    boot(1'h1, 1'h0);
    conclude();
  end
  // A hung handshake must still reach the verdict.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
endmodule
`default_nettype wire
